// ---- bench/tb.sv ----
// Self-checking bench of the transmit scheduler: APB set-up, triggers, frame checks.
// Assumes tps_od_model on the far side and tps_checker bound into the design.
`timescale 1ns/1ps
module tb;
	logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, stall;
	logic                nmt_operational, comm_restart, sync_pulse, rtr_pulse;
	logic                od_rd, tx_valid, tx_ready;
	logic [10:0]         paddr, rtr_id;
	logic [31:0]         pwdata, prdata, od_data;
	logic [15:0]         od_index;
	logic [7:0]          od_sub, sync_count, bias;
	tps_pkg::tps_frame_t tx_frame;
	tps_pkg::tps_frame_t fq[$];
	int                  ft[$];
	int                  cyc, tl, t0, n_mismatch, compares;
	logic [31:0]         ent[4] = '{32'h6041_0010, 32'h6064_0020, 32'h6044_0010, 32'h60FD_0020};

	always #2 pclk = ~pclk;

	tps_scheduler #(.TICK_CYC(10)) u_dut (
		.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
		.nmt_operational, .comm_restart, .sync_pulse, .sync_count, .rtr_pulse, .rtr_id,
		.od_rd, .od_index, .od_sub, .od_data, .tx_valid, .tx_frame, .tx_ready
	);
	tps_od_model u_od (
		.pclk, .presetn, .od_rd, .od_index, .od_sub, .bias, .stall, .od_data, .tx_ready
	);

	task automatic results;
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	// Accepted frames are logged with the cycle of acceptance; a hang ends the run.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			fq.push_back(tx_frame);
			ft.push_back(cyc);
		end
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic acc(input logic w, input logic [10:0] a, input logic [31:0] d, input logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		if (!w && !e) chk(prdata, d);
		chk(pslverr, e);
	endtask : acc

	task automatic getf(input logic [10:0] id, input logic [3:0] l, input logic [63:0] d);
		int k;
		k = -1;
		repeat (3000) if (k < 0) begin
			@(posedge pclk);
			foreach (fq[j]) if (k < 0 && fq[j].id === id) k = j;
		end
		chk(k >= 0, 1);
		if (k >= 0) begin
			chk(fq[k].dlc, l);
			chk(fq[k].data, d);
			tl = ft[k];
			fq.delete(k);
			ft.delete(k);
		end
	endtask : getf

	function automatic logic [63:0] cnt(input logic [10:0] id);
		cnt = 64'h0;
		foreach (fq[k]) if (fq[k].id === id) cnt++;
	endfunction : cnt

	task automatic pulse(input logic s, input logic r, input logic [10:0] id);
		sync_count   <= sync_count + {7'h00, s};
		sync_pulse   <= s;
		comm_restart <= r;
		rtr_pulse    <= !s && !r;
		rtr_id       <= id;
		@(posedge pclk);
		{sync_pulse, comm_restart, rtr_pulse} <= 3'h0;
		repeat (20) @(posedge pclk);
	endtask : pulse

	initial begin
		{pclk, presetn, psel, penable, pwrite, nmt_operational, comm_restart, stall} = '0;
		{sync_pulse, rtr_pulse, paddr, rtr_id, pwdata, sync_count} = '0;
		bias = 8'h11;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			acc(1'b0, {2'b00, m[1:0], 7'h18}, (m == 0) ? 32'h2 : 32'h1, 1'b0);
			acc(1'b0, {2'b00, m[1:0], 7'h44}, ent[m], 1'b0);
			acc(1'b0, {2'b00, m[1:0], 7'h00}, 32'h181 + {m[1:0], 8'h00}, 1'b0);
		end
		$display("test reset values done");
		stall <= 1'b1;
		nmt_operational <= 1'b1;
		repeat (30) @(posedge pclk);
		stall <= 1'b0;
		getf(11'h181, 4'h3, 64'h0061_6041);
		getf(11'h281, 4'h4, {32'h0, bias, 24'h00_6064});
		getf(11'h381, 4'h2, 64'h6044);
		getf(11'h481, 4'h4, {32'h0, bias, 24'h00_60FD});
		// Captures queued while the sink stalled may repeat frames; let them drain.
		repeat (100) @(posedge pclk);
		fq.delete();
		ft.delete();
		$display("test operational entry done");
		acc(1'b1, 11'h088, 32'h5, 1'b0);
		bias <= 8'h22;
		getf(11'h281, 4'h4, {32'h0, 8'h22, 24'h00_6064});
		t0 = tl;
		bias <= 8'h33;
		getf(11'h281, 4'h4, {32'h0, 8'h33, 24'h00_6064});
		chk(tl - t0 >= 50, 1);
		$display("test inhibit done");
		acc(1'b1, 11'h110, 32'h1, 1'b0);
		getf(11'h381, 4'h2, 64'h6044);
		t0 = tl;
		getf(11'h381, 4'h2, 64'h6044);
		chk((tl - t0) inside {[96:104]}, 1);
		acc(1'b1, 11'h110, 32'h0, 1'b0);
		$display("test event timer done");
		for (int n = 1; n < 3; n++) begin
			acc(1'b1, 11'h084, 32'(n), 1'b0);
			fq.delete();
			ft.delete();
			repeat (4) pulse(1'b1, 1'b0, 11'h000);
			chk(cnt(11'h281), 64'(4 / n));
		end
		$display("test sync types done");
		acc(1'b1, 11'h000, 32'h8000_0123, 1'b0);
		acc(1'b0, 11'h000, 32'h8000_0181, 1'b0);
		acc(1'b1, 11'h204, 32'hFD, 1'b0);
		acc(1'b1, 11'h244, 32'h6041_0010, 1'b0);
		acc(1'b1, 11'h248, 32'h6064_0040, 1'b0);
		acc(1'b1, 11'h218, 32'h2, 1'b1);
		acc(1'b1, 11'h218, 32'h1, 1'b0);
		acc(1'b1, 11'h248, 32'h0, 1'b1);
		acc(1'b1, 11'h20C, 32'h5, 1'b0);
		acc(1'b0, 11'h20C, 32'h5, 1'b0);
		acc(1'b0, 11'h21C, 32'h0, 1'b1);
		acc(1'b1, 11'h200, 32'h555, 1'b0);
		fq.delete();
		ft.delete();
		pulse(1'b0, 1'b0, 11'h555);
		chk(cnt(11'h555), 64'h0);
		pulse(1'b0, 1'b1, 11'h000);
		pulse(1'b0, 1'b0, 11'h555);
		getf(11'h555, 4'h2, 64'h6041);
		acc(1'b1, 11'h218, 32'h0, 1'b0);
		pulse(1'b0, 1'b0, 11'h555);
		chk(cnt(11'h555), 64'h0);
		$display("test identifiers and remote requests done");
		acc(1'b1, 11'h084, 32'hFC, 1'b0);
		bias <= 8'h44;
		fq.delete();
		ft.delete();
		pulse(1'b1, 1'b0, 11'h000);
		chk(cnt(11'h281), 64'h0);
		bias <= 8'h55;
		pulse(1'b0, 1'b0, 11'h281);
		getf(11'h281, 4'h4, {32'h0, 8'h44, 24'h00_6064});
		bias <= 8'h44;
		acc(1'b1, 11'h084, 32'h0, 1'b0);
		fq.delete();
		ft.delete();
		bias <= 8'h66;
		getf(11'h281, 4'h4, {32'h0, 8'h44, 24'h00_6064});
		pulse(1'b1, 1'b0, 11'h000);
		repeat (20) @(posedge pclk);
		fq.delete();
		ft.delete();
		repeat (30) @(posedge pclk);
		chk(cnt(11'h281), 64'h0);
		acc(1'b1, 11'h404, 32'h10, 1'b0);
		acc(1'b1, 11'h094, {24'h0, sync_count + 8'h02}, 1'b0);
		acc(1'b1, 11'h084, 32'h1, 1'b0);
		fq.delete();
		ft.delete();
		pulse(1'b1, 1'b0, 11'h000);
		chk(cnt(11'h281), 64'h0);
		repeat (2) pulse(1'b1, 1'b0, 11'h000);
		chk(cnt(11'h281), 64'h2);
		$display("test sync start and capture modes done");
		results();
	end
endmodule : tb

// ---- bench/tps_checker.sv ----
// Port-level assertions for the transmit scheduler.
// Assumes it is bound into tps_scheduler and runs on its single clock.
`timescale 1ns/1ps
module tps_checker #(
	parameter int NMAP     = 8,
	parameter int NENT     = 15,
	parameter int TICK_CYC = 25000
) (
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire logic                od_rd,
	input wire logic [15:0]         od_index,
	input wire logic [7:0]          od_sub,
	input wire logic                tx_valid,
	input wire tps_pkg::tps_frame_t tx_frame,
	input wire logic                tx_ready
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	setup_quiet_a: assert property (psel && !penable |-> !pready)
		else $error("ready raised in setup cycle");
	access_answer_a: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered after one wait state");
	ready_once_a: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	error_with_ready_a: assert property (pslverr |-> pready && psel && penable)
		else $error("error flag outside an answered access");
	od_single_a: assert property (od_rd |=> !od_rd)
		else $error("object requests closer than two cycles");
	od_hold_a: assert property (od_rd |=> $stable(od_index) && $stable(od_sub))
		else $error("object address moved during answer cycle");
	frame_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
		else $error("frame changed or dropped before acceptance");
	frame_release_a: assert property (tx_valid && tx_ready |=> !tx_valid)
		else $error("frame still offered after acceptance");
	dlc_max_a: assert property (tx_valid |-> tx_frame.dlc <= 4'h8)
		else $error("frame longer than eight bytes");
endmodule : tps_checker

bind tps_scheduler tps_checker #(.NMAP(NMAP), .NENT(NENT), .TICK_CYC(TICK_CYC)) u_chk (
	.pclk, .presetn, .psel, .penable, .pready, .pslverr, .od_rd, .od_index, .od_sub,
	.tx_valid, .tx_frame, .tx_ready
);

// ---- bench/tps_od_model.sv ----
// Far-side model: object store with a one-cycle answer, and a frame sink.
// Assumes the scheduler asks for objects with single-cycle od_rd pulses.
`timescale 1ns/1ps
module tps_od_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        od_rd,
	input  wire logic [15:0] od_index,
	input  wire logic [7:0]  od_sub,
	input  wire logic [7:0]  bias,
	input  wire logic        stall,
	output logic      [31:0] od_data,
	output logic             tx_ready
);
	// Objects read as {bias, subindex, index}; outside the answer cycle the bus toggles.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			od_data <= 32'h0000_0000;
		end else if (od_rd) begin
			od_data <= {bias, od_sub, od_index};
		end else begin
			od_data <= ~od_data;
		end
	end
	// The sink refuses frames while stalled, so the scheduler must hold its offer.
	assign tx_ready = !stall;
endmodule : tps_od_model

// ---- hdl/tps_packer.sv ----
// Packs mapped source fields, lowest bit first, into one frame payload.
// Assumes the caller never adds more than 64 bits between two clears.
`timescale 1ns/1ps
module tps_packer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clr,
	input  wire logic        add,
	input  wire logic [7:0]  len,
	input  wire logic [31:0] data,
	output logic      [63:0] payload,
	output logic      [6:0]  nbits
);
	logic [31:0] mask;

	always_comb begin
		if (len >= 8'h20) begin
			mask = 32'hFFFF_FFFF;
		end else begin
			mask = (32'h0000_0001 << len[4:0]) - 32'h0000_0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			payload <= 64'h0;
			nbits   <= 7'h00;
		end else if (clr) begin
			payload <= 64'h0;
			nbits   <= 7'h00;
		end else if (add) begin
			payload <= payload | ({32'h0, data & mask} << nbits);
			nbits   <= 7'(nbits + len[6:0]);
		end
	end
endmodule : tps_packer

// ---- hdl/tps_pkg.sv ----
// Types shared by the transmit scheduler, its checker and its bench.
// Assumes the constants of tps_regs.svh.
package tps_pkg;
	typedef enum logic [1:0] {
		TPS_IDLE  = 2'b00,
		TPS_FETCH = 2'b01,
		TPS_ADD   = 2'b11,
		TPS_DONE  = 2'b10
	} tps_state_t;
	typedef struct packed {
		logic [15:0] index;
		logic [7:0]  sub;
		logic [7:0]  len;
	} tps_entry_t;
	typedef struct packed {
		logic [10:0] id;
		logic [3:0]  dlc;
		logic [63:0] data;
	} tps_frame_t;
endpackage : tps_pkg

// ---- hdl/tps_regs.svh ----
// Register offsets, reset values, type codes and timing figures of the transmit scheduler.
// Assumes a 32-bit APB word map with an 11-bit byte address.
`ifndef TPS_REGS_SVH
`define TPS_REGS_SVH
`define TPS_GLB_BIT       10
`define TPS_OFF_COBID     7'h00
`define TPS_OFF_TTYPE     7'h04
`define TPS_OFF_INHIBIT   7'h08
`define TPS_OFF_COMPAT    7'h0C
`define TPS_OFF_EVTIMER   7'h10
`define TPS_OFF_SSTART    7'h14
`define TPS_OFF_COUNT     7'h18
`define TPS_ADR_NODE      11'h400
`define TPS_ADR_SYNCOVF   11'h404
`define TPS_ADR_STATUS    11'h408
`define TPS_VALID_BIT     31
`define TPS_BASE1         11'h180
`define TPS_BASE2         11'h280
`define TPS_BASE3         11'h380
`define TPS_BASE4         11'h480
`define TPS_NODE_RST      7'h01
`define TPS_SYNCOVF_RST   8'h00
`define TPS_TT_RST        8'hFF
`define TPS_TT_ACYC       8'h00
`define TPS_TT_CYC_MAX    8'hF0
`define TPS_TT_RTR_SYNC   8'hFC
`define TPS_TT_RTR_EVT    8'hFD
`define TPS_TT_ASYNC      8'hFE
`define TPS_COBID_ON_RST  32'h0000_0000
`define TPS_COBID_OFF_RST 32'h8000_0000
`define TPS_M1E1_RST      32'h6041_0010
`define TPS_M1E2_RST      32'h6061_0008
`define TPS_M2E1_RST      32'h6064_0020
`define TPS_M3E1_RST      32'h6044_0010
`define TPS_M4E1_RST      32'h60FD_0020
`define TPS_MAX_BITS      9'h040
`define TPS_TICK_US       100
`define TPS_CLK_MHZ       250
`define TPS_TICKS_PER_MS  10
`endif

// ---- hdl/tps_scheduler.sv ----
// Transmit process-data scheduler: mapping registers on APB, capture engine and frame sender.
// Assumes the object port answers one cycle after od_rd and the frame sink handshakes.
// Function
// - Mappings one to four use base plus node
// - Fixed ids: only valid bit writable
// - New identifier applies only after restart
// - Operational entry, data change, timer raise event
// - Event timer restarts on own expiry and while disabled
// - Type 0: capture on sync, send on event
// - Types 1..240: capture nth sync, send
// - Type FC: capture each sync, send on request
// - Type FD: capture and send on request
// - Types FE, FF: capture and send on event
// - Inhibit time in 100 us between sends
// - Inhibit applies to asynchronous frames only
// - Compatibility entry stored, without effect
// - Event timer in ms triggers capture, send for FE, FF; send only for type 0
// - Sync start value gates first sync send
// - Count zero disables the mapping
// - Entries consumed in order without gaps
// - Entry holds index, subindex, bit length
// - Capture and send are separate actions
// - Reset defaults for mappings one to four
// - Valid bit set disables; entries writable only at count zero
`timescale 1ns/1ps
`include "tps_regs.svh"
module tps_scheduler #(
	parameter int NMAP     = 8,
	parameter int NENT     = 15,
	parameter int TICK_CYC = `TPS_TICK_US * `TPS_CLK_MHZ
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic [10:0]        paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic                    pready,
	output logic      [31:0]        prdata,
	output logic                    pslverr,
	input  wire logic               nmt_operational,
	input  wire logic               comm_restart,
	input  wire logic               sync_pulse,
	input  wire logic [7:0]         sync_count,
	input  wire logic               rtr_pulse,
	input  wire logic [10:0]        rtr_id,
	output logic                    od_rd,
	output logic      [15:0]        od_index,
	output logic      [7:0]         od_sub,
	input  wire logic [31:0]        od_data,
	output logic                    tx_valid,
	output tps_pkg::tps_frame_t     tx_frame,
	input  wire logic               tx_ready
);
	localparam int TW = $clog2(TICK_CYC + 1);

	logic [31:0] cobid [NMAP];
	logic [7:0]  ttype [NMAP];
	logic [15:0] inhibit [NMAP];
	logic [7:0]  compat [NMAP];
	logic [15:0] evtmr [NMAP];
	logic [7:0]  sstart [NMAP];
	logic [3:0]  cnt [NMAP];
	logic [31:0] ent [NMAP][NENT];
	logic [6:0]  node_id;
	logic [7:0]  sync_ovf;
	logic [10:0] act_id [NMAP];
	logic [63:0] buf_data [NMAP];
	logic [3:0]  buf_dlc [NMAP];
	logic [63:0] last [NMAP];
	logic [7:0]  cyc_cnt [NMAP];
	logic [16:0] inh_cnt [NMAP];
	logic [15:0] ev_cnt [NMAP];
	logic [NMAP-1:0] started, capq, capsnd, txp, chg, tmr_exp;
	logic [NMAP-1:0] en, asy, fire, capset, sndset, txset, sendable;
	logic [TW-1:0]   tick_cnt;
	logic [3:0]      ms_cnt;
	logic            tick, ms_tick, op_d, op_rise;
	logic [31:0]     rd_val;
	logic            bad, wr;
	logic [2:0]      am;
	logic [6:0]      off;
	logic [3:0]      ek;
	tps_pkg::tps_state_t st;
	logic [2:0]      e_map, poll_m, cap_m, snd_m;
	logic [3:0]      e_k;
	logic            e_poll, e_send, eng_send, take, poll_go, snd_go;
	logic [63:0]     payload;
	logic [6:0]      nbits;
	tps_pkg::tps_entry_t cur_ent;

	function automatic logic [10:0] id_of(input int m, input logic [31:0] c, input logic [6:0] n);
		logic [10:0] b;
		b = c[10:0];
		case (m)
			0: b = `TPS_BASE1 + {4'h0, n};
			1: b = `TPS_BASE2 + {4'h0, n};
			2: b = `TPS_BASE3 + {4'h0, n};
			3: b = `TPS_BASE4 + {4'h0, n};
			default: b = c[10:0];
		endcase
		return b;
	endfunction : id_of

	function automatic logic [8:0] sum_len(input logic [2:0] m, input logic [3:0] n);
		logic [8:0] s;
		s = 9'h000;
		for (int k = 0; k < NENT; k++) begin
			if (k < int'(n)) s = s[8] ? 9'h1FF : s + {1'b0, ent[m][k][7:0]};
		end
		return s;
	endfunction : sum_len

	function automatic logic [2:0] first_set(input logic [NMAP-1:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = NMAP - 1; i >= 0; i--) begin
			if (v[i]) r = 3'(i);
		end
		return r;
	endfunction : first_set

	// Register decode, read mux and refusal of illegal writes.
	always_comb begin
		am     = paddr[9:7];
		off    = paddr[6:0];
		ek     = off[5:2];
		rd_val = 32'h0000_0000;
		bad    = 1'b0;
		if (paddr[`TPS_GLB_BIT]) begin
			case (paddr)
				`TPS_ADR_NODE:    rd_val = {25'h0, node_id};
				`TPS_ADR_SYNCOVF: rd_val = {24'h0, sync_ovf};
				`TPS_ADR_STATUS:  rd_val = {23'h0, st != tps_pkg::TPS_IDLE, 8'(txp)};
				default:          bad = 1'b1;
			endcase
		end else if (off[6]) begin
			if (ek == 4'h0) begin
				bad = 1'b1;
			end else begin
				rd_val = ent[am][ek - 4'h1];
				bad = pwrite && cnt[am] != 4'h0;
			end
		end else begin
			case (off)
				`TPS_OFF_COBID:   rd_val = {cobid[am][31], 20'h0, id_of(int'(am), cobid[am], node_id)};
				`TPS_OFF_TTYPE:   rd_val = {24'h0, ttype[am]};
				`TPS_OFF_INHIBIT: rd_val = {16'h0, inhibit[am]};
				`TPS_OFF_COMPAT:  rd_val = {24'h0, compat[am]};
				`TPS_OFF_EVTIMER: rd_val = {16'h0, evtmr[am]};
				`TPS_OFF_SSTART:  rd_val = {24'h0, sstart[am]};
				`TPS_OFF_COUNT: begin
					rd_val = {28'h0, cnt[am]};
					bad = pwrite && ((|pwdata[31:4]) || int'(pwdata[3:0]) > NENT ||
						sum_len(am, pwdata[3:0]) > `TPS_MAX_BITS);
				end
				default: bad = 1'b1;
			endcase
		end
	end

	assign wr = psel & penable & pready & pwrite & ~pslverr;

	// APB answer: one wait state, then pready with data and error for one cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel & penable & ~pready) begin
			pready  <= 1'b1;
			prdata  <= rd_val;
			pslverr <= bad;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			node_id  <= `TPS_NODE_RST;
			sync_ovf <= `TPS_SYNCOVF_RST;
			for (int m = 0; m < NMAP; m++) begin
				cobid[m]   <= (m < 4) ? `TPS_COBID_ON_RST : `TPS_COBID_OFF_RST;
				ttype[m]   <= `TPS_TT_RST;
				inhibit[m] <= 16'h0000;
				compat[m]  <= 8'h00;
				evtmr[m]   <= 16'h0000;
				sstart[m]  <= 8'h00;
				cnt[m]     <= 4'h0;
				for (int k = 0; k < NENT; k++) ent[m][k] <= 32'h0000_0000;
			end
			ent[0][0] <= `TPS_M1E1_RST;
			ent[0][1] <= `TPS_M1E2_RST;
			ent[1][0] <= `TPS_M2E1_RST;
			ent[2][0] <= `TPS_M3E1_RST;
			ent[3][0] <= `TPS_M4E1_RST;
			cnt[0] <= 4'h2;
			cnt[1] <= 4'h1;
			cnt[2] <= 4'h1;
			cnt[3] <= 4'h1;
		end else if (wr) begin
			if (paddr == `TPS_ADR_NODE) node_id <= pwdata[6:0];
			if (paddr == `TPS_ADR_SYNCOVF) sync_ovf <= pwdata[7:0];
			if (!paddr[`TPS_GLB_BIT] && off[6]) ent[am][ek - 4'h1] <= pwdata;
			if (!paddr[`TPS_GLB_BIT] && !off[6]) begin
				case (off)
					`TPS_OFF_COBID: begin
						if (am < 3'h4) begin
							cobid[am][`TPS_VALID_BIT] <= pwdata[31];
						end else begin
							cobid[am] <= {pwdata[31], 20'h0, pwdata[10:0]};
						end
					end
					`TPS_OFF_TTYPE:   ttype[am] <= pwdata[7:0];
					`TPS_OFF_INHIBIT: inhibit[am] <= pwdata[15:0];
					`TPS_OFF_COMPAT:  compat[am] <= pwdata[7:0];
					`TPS_OFF_EVTIMER: evtmr[am] <= pwdata[15:0];
					`TPS_OFF_SSTART:  sstart[am] <= pwdata[7:0];
					`TPS_OFF_COUNT:   cnt[am] <= pwdata[3:0];
					default: ;
				endcase
			end
		end
	end

	// Trigger decode per mapping.
	always_comb begin
		logic [7:0] tt;
		logic       gate, cyc, rtr, ev;
		tt = 8'h00;
		gate = 1'b0;
		cyc = 1'b0;
		rtr = 1'b0;
		ev = 1'b0;
		for (int m = 0; m < NMAP; m++) begin
			tt = ttype[m];
			en[m] = nmt_operational & ~cobid[m][`TPS_VALID_BIT] & (cnt[m] != 4'h0);
			asy[m] = tt >= `TPS_TT_ASYNC;
			gate = !(sync_ovf > 8'h01 && sstart[m] != 8'h00) || started[m] ||
				sync_count == sstart[m];
			cyc = tt != `TPS_TT_ACYC && tt <= `TPS_TT_CYC_MAX;
			fire[m] = sync_pulse & en[m] & cyc & gate & (8'(cyc_cnt[m] + 8'h01) == tt);
			rtr = rtr_pulse & en[m] & (rtr_id == act_id[m]);
			ev = en[m] & (op_rise | chg[m] | tmr_exp[m]);
			capset[m] = (sync_pulse & en[m] & (tt == `TPS_TT_ACYC || tt == `TPS_TT_RTR_SYNC)) |
				fire[m] | (rtr & tt == `TPS_TT_RTR_EVT) | (ev & asy[m]);
			sndset[m] = fire[m] | (rtr & tt == `TPS_TT_RTR_EVT) | (ev & asy[m]);
			txset[m] = (ev & tt == `TPS_TT_ACYC) | (rtr & tt == `TPS_TT_RTR_SYNC) |
				(eng_send & e_map == 3'(m));
			sendable[m] = txp[m] & en[m] & (~asy[m] | inh_cnt[m] == 17'h0);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			started <= '0;
			for (int m = 0; m < NMAP; m++) begin
				act_id[m]  <= (m < 4) ? id_of(m, 32'h0, `TPS_NODE_RST) : 11'h000;
				cyc_cnt[m] <= 8'h00;
			end
		end else if (comm_restart) begin
			started <= '0;
			for (int m = 0; m < NMAP; m++) begin
				act_id[m]  <= id_of(m, cobid[m], node_id);
				cyc_cnt[m] <= 8'h00;
			end
		end else if (sync_pulse) begin
			for (int m = 0; m < NMAP; m++) begin
				if (en[m] && ttype[m] != `TPS_TT_ACYC && ttype[m] <= `TPS_TT_CYC_MAX &&
					(started[m] || !(sync_ovf > 8'h01 && sstart[m] != 8'h00) ||
					sync_count == sstart[m])) begin
					started[m] <= 1'b1;
					cyc_cnt[m] <= fire[m] ? 8'h00 : 8'(cyc_cnt[m] + 8'h01);
				end
			end
		end
	end

	assign tick    = tick_cnt == TW'(TICK_CYC - 1);
	assign ms_tick = tick && ms_cnt == 4'(`TPS_TICKS_PER_MS - 1);
	assign op_rise = nmt_operational & ~op_d;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= '0;
			ms_cnt   <= 4'h0;
			op_d     <= 1'b0;
			tmr_exp  <= '0;
			for (int m = 0; m < NMAP; m++) begin
				inh_cnt[m] <= 17'h0;
				ev_cnt[m]  <= 16'h0000;
			end
		end else begin
			tick_cnt <= tick ? '0 : TW'(tick_cnt + 1'b1);
			if (tick) ms_cnt <= ms_tick ? 4'h0 : 4'(ms_cnt + 4'h1);
			op_d <= nmt_operational;
			tmr_exp <= '0;
			for (int m = 0; m < NMAP; m++) begin
				// Loading one extra tick keeps the gap at least the programmed time.
				if (snd_go && snd_m == 3'(m) && asy[m] && inhibit[m] != 16'h0000) begin
					inh_cnt[m] <= {1'b0, inhibit[m]} + 17'h1;
				end else if (tick && inh_cnt[m] != 17'h0) begin
					inh_cnt[m] <= inh_cnt[m] - 17'h1;
				end
				if (!en[m] || evtmr[m] == 16'h0000) begin
					ev_cnt[m] <= evtmr[m];
				end else if (ms_tick) begin
					if (ev_cnt[m] <= 16'h0001) begin
						ev_cnt[m]  <= evtmr[m];
						tmr_exp[m] <= 1'b1;
					end else begin
						ev_cnt[m] <= ev_cnt[m] - 16'h0001;
					end
				end
			end
		end
	end

	assign cap_m   = first_set(capq);
	assign take    = st == tps_pkg::TPS_IDLE && (|capq);
	assign poll_go = st == tps_pkg::TPS_IDLE && !(|capq) && en[poll_m] &&
		(asy[poll_m] || ttype[poll_m] == `TPS_TT_ACYC);
	assign snd_m   = first_set(sendable);
	assign snd_go  = !tx_valid && (|sendable);

	// A new trigger in the cycle that consumes the old one stays pending.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capq   <= '0;
			capsnd <= '0;
			txp    <= '0;
		end else if (comm_restart) begin
			capq   <= '0;
			capsnd <= '0;
			txp    <= '0;
		end else begin
			capq   <= (capq & ~(NMAP'(take) << cap_m)) | capset;
			capsnd <= (capsnd & ~(NMAP'(take) << cap_m)) | sndset;
			txp    <= (txp & ~(NMAP'(snd_go) << snd_m)) | txset;
		end
	end

	assign cur_ent = ent[e_map][e_k];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st       <= tps_pkg::TPS_IDLE;
			e_map    <= 3'h0;
			e_k      <= 4'h0;
			e_poll   <= 1'b0;
			e_send   <= 1'b0;
			eng_send <= 1'b0;
			poll_m   <= 3'h0;
			chg      <= '0;
			od_rd    <= 1'b0;
			od_index <= 16'h0000;
			od_sub   <= 8'h00;
			for (int m = 0; m < NMAP; m++) begin
				buf_data[m] <= 64'h0;
				buf_dlc[m]  <= 4'h0;
			end
		end else begin
			eng_send <= 1'b0;
			chg      <= '0;
			case (st)
				tps_pkg::TPS_IDLE: begin
					if (take || poll_go) begin
						e_map    <= take ? cap_m : poll_m;
						e_poll   <= !take;
						e_send   <= take & capsnd[cap_m];
						e_k      <= 4'h0;
						od_rd    <= 1'b1;
						od_index <= ent[take ? cap_m : poll_m][0][31:16];
						od_sub   <= ent[take ? cap_m : poll_m][0][15:8];
						st       <= tps_pkg::TPS_FETCH;
					end
					if (!take) poll_m <= 3'(poll_m + 3'h1);
				end
				tps_pkg::TPS_FETCH: begin
					od_rd <= 1'b0;
					st    <= tps_pkg::TPS_ADD;
				end
				tps_pkg::TPS_ADD: begin
					if (e_k + 4'h1 < cnt[e_map]) begin
						e_k      <= e_k + 4'h1;
						od_rd    <= 1'b1;
						od_index <= ent[e_map][e_k + 4'h1][31:16];
						od_sub   <= ent[e_map][e_k + 4'h1][15:8];
						st       <= tps_pkg::TPS_FETCH;
					end else begin
						st <= tps_pkg::TPS_DONE;
					end
				end
				tps_pkg::TPS_DONE: begin
					if (e_poll) begin
						chg[e_map] <= payload != last[e_map];
					end else begin
						buf_data[e_map] <= payload;
						buf_dlc[e_map]  <= 4'(7'(nbits + 7'h07) >> 3);
						eng_send        <= e_send;
					end
					st <= tps_pkg::TPS_IDLE;
				end
				default: st <= tps_pkg::TPS_IDLE;
			endcase
		end
	end

	tps_packer u_packer (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (st == tps_pkg::TPS_IDLE),
		.add     (st == tps_pkg::TPS_ADD),
		.len     (cur_ent.len),
		.data    (od_data),
		.payload (payload),
		.nbits   (nbits)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_valid <= 1'b0;
			tx_frame <= '0;
			for (int m = 0; m < NMAP; m++) last[m] <= 64'h0;
		end else if (tx_valid) begin
			if (tx_ready) tx_valid <= 1'b0;
		end else if (snd_go) begin
			tx_valid       <= 1'b1;
			tx_frame.id    <= act_id[snd_m];
			tx_frame.dlc   <= buf_dlc[snd_m];
			tx_frame.data  <= buf_data[snd_m];
			last[snd_m]    <= buf_data[snd_m];
		end
	end
endmodule : tps_scheduler
